// ### shared/vic_pkg.sv
/*
 * Shared constants and types for the vectored interrupt controller:
 * source counts, vector table layout, control field positions and
 * fixed latencies.
 * Assumes program memory is word addressed with 24-bit entries.
 */
package vic_pkg;

   // ==========================================================
   // Source counts and widths
   // ==========================================================
   localparam int VIC_NUM_TRAP = 8;
   localparam int VIC_NUM_IRQ = 118;
   localparam int VIC_NUM_VEC = VIC_NUM_TRAP + VIC_NUM_IRQ;
   localparam int VIC_SLOT_W = 7;
   localparam int VIC_PRI_W = 3;
   localparam int VIC_LVL_W = 4;
   localparam int VIC_ADDR_W = 24;
   localparam int VIC_BOOT_SEGMENT_LIMIT_W = 13;
   localparam int VIC_CFG_W = 16;

   // ==========================================================
   // Priority levels
   // ==========================================================
   // Traps sit above the seven user levels; zero disables a source
   localparam logic [VIC_LVL_W-1:0] VIC_TRAP_LVL = 4'h8;
   localparam logic [VIC_LVL_W-1:0] VIC_LVL_NONE = 4'h0;

   // ==========================================================
   // Vector table layout
   // ==========================================================
   localparam logic [VIC_ADDR_W-1:0] VIC_PRIMARY_BASE = 24'h000004;
   localparam int VIC_SLOT_SHIFT = 1;
   localparam int VIC_ALT_PAGE_SHIFT = 11;
   localparam logic [VIC_ADDR_W-1:0] VIC_RESET_ADDR = 24'h000000;

   // ==========================================================
   // Control field positions
   // ==========================================================
   localparam int VIC_ALT_EN_BIT = 8;
   localparam int VIC_ALT_PERMIT_BIT = 15;

   // ==========================================================
   // Fixed latencies in clock cycles
   // ==========================================================
   localparam int VIC_PM_LAT = 1;
   localparam int VIC_RET_LAT = 2;

   // ==========================================================
   // Types
   // ==========================================================
   typedef logic [VIC_PRI_W-1:0] vic_pri_type;
   typedef logic [VIC_LVL_W-1:0] vic_lvl_type;

   typedef struct packed {
      logic [VIC_ADDR_W-1:0] addr;
      vic_lvl_type level;
      logic [VIC_SLOT_W-1:0] slot;
   } vic_vector_type;

   typedef struct packed {
      logic alt_enable;
      logic alt_permit;
      logic boot_defined;
      logic [VIC_BOOT_SEGMENT_LIMIT_W-1:0] boot_limit;
   } vic_cfg_type;

endpackage

// ### verilog/vic_arbiter.sv
/*
 * Combinational priority arbiter: picks the pending source with the
 * highest effective level, lowest slot first on a tie.
 * Assumes pending and level inputs are stable within the clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module vic_arbiter
   import vic_pkg::*;
#(
   parameter int NUM_TRAP = VIC_NUM_TRAP,
   parameter int NUM_IRQ = VIC_NUM_IRQ
) (
   input wire logic [NUM_TRAP-1:0] trap_pend,
   input wire logic [NUM_IRQ-1:0] irq_pend,
   input wire vic_pri_type [NUM_IRQ-1:0] irq_level,
   input wire vic_pri_type cpu_level,
   output logic win_valid,
   output logic [VIC_SLOT_W-1:0] win_slot,
   output vic_lvl_type win_level
);

   localparam int NUM_VEC = NUM_TRAP + NUM_IRQ;

   vic_lvl_type eff_lvl [NUM_VEC];
   logic [NUM_VEC-1:0] eligible;

   // ==========================================================
   // Effective level per slot
   // ==========================================================
   for (genvar i = 0; i < NUM_VEC; i++) begin : g_slot
      if (i < NUM_TRAP) begin : g_trap
         // Traps cannot be masked by the core level
         assign eff_lvl[i] = trap_pend[i] ? VIC_TRAP_LVL : VIC_LVL_NONE;
      end else begin : g_irq
         assign eff_lvl[i] = irq_pend[i-NUM_TRAP] ?
            {1'b0, irq_level[i-NUM_TRAP]} : VIC_LVL_NONE;
      end
      assign eligible[i] = eff_lvl[i] > {1'b0, cpu_level};
   end

   // ==========================================================
   // Selection
   // ==========================================================
   // Scanning downward with >= lets the lower slot win a tie
   always_comb begin
      win_valid = 1'b0;
      win_slot = '0;
      win_level = VIC_LVL_NONE;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (eligible[i] && eff_lvl[i] >= win_level) begin
            win_valid = 1'b1;
            win_slot = VIC_SLOT_W'(i);
            win_level = eff_lvl[i];
         end
      end
   end

endmodule // vic_arbiter

`default_nettype wire

// ### verilog/vic_top.sv
/*
 * Vectored interrupt controller top: merges trap and peripheral
 * requests into one core request, fetches the handler address from
 * the primary or alternate vector table and times entry and return.
 * Assumes requests, levels and configuration come from logic on clk,
 * and that program memory answers a read after a fixed latency.
 */
`timescale 1ns/1ns
`default_nettype none

module vic_top
   import vic_pkg::*;
#(
   parameter int NUM_TRAP = VIC_NUM_TRAP,
   parameter int NUM_IRQ = VIC_NUM_IRQ,
   parameter int PM_LAT = VIC_PM_LAT,
   parameter int RET_LAT = VIC_RET_LAT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [NUM_TRAP-1:0] trap_pend,
   input wire logic [NUM_IRQ-1:0] irq_pend,
   input wire vic_pri_type [NUM_IRQ-1:0] irq_level,
   input wire vic_pri_type cpu_level,
   input wire logic [VIC_CFG_W-1:0] interrupt_control_second,
   input wire logic [VIC_CFG_W-1:0] security_config_word,
   input wire logic boot_segment_defined,
   input wire logic [VIC_BOOT_SEGMENT_LIMIT_W-1:0] boot_segment_limit,
   input wire logic core_ack,
   input wire logic core_return,
   input wire logic [VIC_ADDR_W-1:0] pm_rd_data,
   output logic core_irq,
   output vic_lvl_type core_irq_level,
   output vic_vector_type core_vec,
   output logic core_vec_valid,
   output logic core_ret_done,
   output logic pm_rd_en,
   output logic [VIC_ADDR_W-1:0] pm_rd_addr,
   output logic alt_active,
   output logic in_service
);

   localparam int CNT_W = 8;

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (NUM_TRAP < 1 || NUM_TRAP > 8) begin : g_bad_trap
      $error("vic_top: NUM_TRAP must be 1..8");
   end
   if (NUM_IRQ < 1 || NUM_TRAP + NUM_IRQ > (1 << VIC_SLOT_W)) begin : g_bad_irq
      $error("vic_top: too many vector slots");
   end
   if (PM_LAT < 1 || PM_LAT > 255) begin : g_bad_pm
      $error("vic_top: PM_LAT must be 1..255");
   end
   if (RET_LAT < 1 || RET_LAT > 255) begin : g_bad_ret
      $error("vic_top: RET_LAT must be 1..255");
   end

   // ==========================================================
   // Declarations
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REQ,
      ST_FETCH,
      ST_SERVE,
      ST_RET
   } vic_state_type;

   vic_state_type state_ff;
   vic_state_type nxt_state;
   vic_cfg_type cfg;
   logic alt_sel;
   logic [VIC_ADDR_W-1:0] alt_base;
   logic [VIC_ADDR_W-1:0] table_base;
   logic [VIC_ADDR_W-1:0] slot_offset;
   logic win_valid;
   logic [VIC_SLOT_W-1:0] win_slot;
   vic_lvl_type win_level;
   logic [VIC_SLOT_W-1:0] slot_ff;
   vic_lvl_type level_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic core_irq_ff;
   vic_lvl_type core_irq_level_ff;
   vic_vector_type core_vec_ff;
   logic core_vec_valid_ff;
   logic core_ret_done_ff;
   logic pm_rd_en_ff;
   logic [VIC_ADDR_W-1:0] pm_rd_addr_ff;
   logic alt_active_ff;
   logic in_service_ff;
   logic accept;
   logic fetch_done;
   logic ret_last;

   // ==========================================================
   // Table selection
   // ==========================================================
   assign cfg.alt_enable = interrupt_control_second[VIC_ALT_EN_BIT];
   assign cfg.alt_permit = security_config_word[VIC_ALT_PERMIT_BIT];
   assign cfg.boot_defined = boot_segment_defined;
   assign cfg.boot_limit = boot_segment_limit;

   // All three must hold; any one missing falls back to primary
   assign alt_sel = cfg.alt_enable && cfg.alt_permit &&
                    cfg.boot_defined;

   // Start of the last boot segment page
   assign alt_base = {cfg.boot_limit - 13'h0001,
                      {VIC_ALT_PAGE_SHIFT{1'b0}}};

   assign table_base = alt_sel ? alt_base : VIC_PRIMARY_BASE;

   // Same slot spacing for both tables
   assign slot_offset = VIC_ADDR_W'(slot_ff) << VIC_SLOT_SHIFT;

   // ==========================================================
   // Arbitration
   // ==========================================================
   vic_arbiter #(
      .NUM_TRAP(NUM_TRAP),
      .NUM_IRQ(NUM_IRQ)
   ) u_arbiter (
      .trap_pend(trap_pend),
      .irq_pend(irq_pend),
      .irq_level(irq_level),
      .cpu_level(cpu_level),
      .win_valid(win_valid),
      .win_slot(win_slot),
      .win_level(win_level)
   );

   // ==========================================================
   // Sequence control
   // ==========================================================
   assign accept = (state_ff == ST_REQ) && core_ack;
   assign fetch_done = (state_ff == ST_FETCH) && (cnt_ff == '0);
   assign ret_last = (state_ff == ST_RET) && (cnt_ff == 8'h01);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (win_valid) begin
               nxt_state = ST_REQ;
            end
         end
         ST_REQ: begin
            // Acknowledge beats a request that vanishes the same cycle
            if (core_ack) begin
               nxt_state = ST_FETCH;
            end else if (!win_valid) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_FETCH: begin
            if (cnt_ff == '0) begin
               nxt_state = ST_SERVE;
            end
         end
         ST_SERVE: begin
            if (core_return) begin
               nxt_state = ST_RET;
            end
         end
         ST_RET: begin
            if (cnt_ff == 8'h01) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Winner latch
   // ==========================================================
   // Tracks the arbiter until the core takes it, so a higher source
   // arriving before the acknowledge still preempts the offer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         slot_ff <= '0;
         level_ff <= VIC_LVL_NONE;
      end else if (ce) begin
         if ((state_ff == ST_IDLE || state_ff == ST_REQ) && !core_ack &&
             win_valid) begin
            slot_ff <= win_slot;
            level_ff <= win_level;
         end
      end
   end

   // ==========================================================
   // Latency counter
   // ==========================================================
   // Counts are loaded from constants, never from the source
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (ce) begin
         if (accept) begin
            cnt_ff <= CNT_W'(PM_LAT);
         end else if (state_ff == ST_SERVE && core_return) begin
            cnt_ff <= CNT_W'(RET_LAT);
         end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end

   // ==========================================================
   // Core request
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         core_irq_ff <= 1'b0;
         core_irq_level_ff <= VIC_LVL_NONE;
      end else if (ce) begin
         core_irq_ff <= (nxt_state == ST_REQ);
         if (nxt_state == ST_REQ && win_valid && !core_ack) begin
            core_irq_level_ff <= win_level;
         end else if (nxt_state != ST_REQ) begin
            core_irq_level_ff <= VIC_LVL_NONE;
         end
      end
   end

   // ==========================================================
   // Vector fetch
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pm_rd_en_ff <= 1'b0;
         pm_rd_addr_ff <= VIC_RESET_ADDR;
      end else if (ce) begin
         pm_rd_en_ff <= accept;
         if (accept) begin
            pm_rd_addr_ff <= table_base + slot_offset;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         core_vec_ff <= '{addr: VIC_RESET_ADDR, level: VIC_LVL_NONE,
                          slot: '0};
         core_vec_valid_ff <= 1'b0;
      end else if (ce) begin
         core_vec_valid_ff <= fetch_done;
         if (fetch_done) begin
            core_vec_ff.addr <= pm_rd_data;
            core_vec_ff.level <= level_ff;
            core_vec_ff.slot <= slot_ff;
         end
      end
   end

   // ==========================================================
   // Service and return
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_service_ff <= 1'b0;
         core_ret_done_ff <= 1'b0;
      end else if (ce) begin
         in_service_ff <= (nxt_state == ST_SERVE) ||
                          (nxt_state == ST_RET);
         core_ret_done_ff <= ret_last;
      end
   end

   // ==========================================================
   // Status
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alt_active_ff <= 1'b0;
      end else if (ce) begin
         alt_active_ff <= alt_sel;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign core_irq = core_irq_ff;
   assign core_irq_level = core_irq_level_ff;
   assign core_vec = core_vec_ff;
   assign core_vec_valid = core_vec_valid_ff;
   assign core_ret_done = core_ret_done_ff;
   assign pm_rd_en = pm_rd_en_ff;
   assign pm_rd_addr = pm_rd_addr_ff;
   assign alt_active = alt_active_ff;
   assign in_service = in_service_ff;

endmodule // vic_top

`default_nettype wire

// ### testbench/vic_top_sva.sv
/* Checker for vic_top, bound to its ports.
   Assumes ce stays high while the bench runs. */
`timescale 1ns/1ns
`default_nettype none
module vic_top_sva
   import vic_pkg::*;
#(
   parameter int NUM_TRAP = VIC_NUM_TRAP,
   parameter int NUM_IRQ = VIC_NUM_IRQ,
   parameter int PM_LAT = VIC_PM_LAT,
   parameter int RET_LAT = VIC_RET_LAT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_TRAP-1:0] trap_pend,
   input wire logic [NUM_IRQ-1:0] irq_pend,
   input wire vic_pri_type cpu_level,
   input wire logic [VIC_CFG_W-1:0] interrupt_control_second,
   input wire logic [VIC_CFG_W-1:0] security_config_word,
   input wire logic boot_segment_defined,
   input wire logic [VIC_BOOT_SEGMENT_LIMIT_W-1:0] boot_segment_limit,
   input wire logic core_ack,
   input wire logic core_return,
   input wire logic [VIC_ADDR_W-1:0] pm_rd_data,
   input wire logic core_irq,
   input wire vic_lvl_type core_irq_level,
   input wire vic_vector_type core_vec,
   input wire logic core_vec_valid,
   input wire logic core_ret_done,
   input wire logic pm_rd_en,
   input wire logic [VIC_ADDR_W-1:0] pm_rd_addr,
   input wire logic alt_active,
   input wire logic in_service
);
   localparam int FETCH_LAT = PM_LAT + 1;
   localparam int RET_WAIT = RET_LAT + 1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Request and level
   // ==========================================================
   a_irq_has_src: assert property ($rose(core_irq) |->
      $past(|trap_pend || |irq_pend)) else $error("request without source");
   a_trap_level: assert property ($rose(core_irq) && $past(|trap_pend) |->
      core_irq_level == VIC_TRAP_LVL) else $error("trap level wrong");
   a_level_above_cpu: assert property ($rose(core_irq) &&
      core_irq_level != VIC_TRAP_LVL |-> core_irq_level <= 4'h7 &&
      core_irq_level > {1'b0, $past(cpu_level)}) else $error("level not above cpu");
   // ==========================================================
   // Fetch and return timing
   // ==========================================================
   a_ack_fetch: assert property (core_irq && core_ack |=>
      pm_rd_en && !core_irq) else $error("no fetch after ack");
   a_prim_slot: assert property (pm_rd_en && !alt_active |->
      ##FETCH_LAT core_vec_valid && pm_rd_addr == VIC_PRIMARY_BASE +
      {16'h0000, core_vec.slot, 1'b0}) else $error("primary address wrong");
   a_alt_slot: assert property (pm_rd_en && alt_active |->
      ##FETCH_LAT core_vec_valid && pm_rd_addr == {boot_segment_limit -
      13'h0001, 11'h000} + {16'h0000, core_vec.slot, 1'b0})
      else $error("alternate address wrong");
   a_alt_select: assert property (pm_rd_en |-> alt_active ==
      ($past(interrupt_control_second[VIC_ALT_EN_BIT]) &&
      $past(security_config_word[VIC_ALT_PERMIT_BIT]) &&
      $past(boot_segment_defined))) else $error("table choice wrong");
   a_vec_data: assert property (core_vec_valid |-> in_service &&
      core_vec.addr == $past(pm_rd_data)) else $error("vector data wrong");
   a_return_lat: assert property (core_return && in_service |->
      ##RET_WAIT core_ret_done && !in_service) else $error("return late");
   a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |=> core_vec.addr == VIC_RESET_ADDR && !core_irq && !in_service)
      else $error("reset did not clear");
   c_alt: cover property (core_vec_valid && alt_active);
   c_trap: cover property (core_vec_valid && core_vec.level == VIC_TRAP_LVL);
   c_done: cover property (core_ret_done);
endmodule // vic_top_sva
bind vic_top vic_top_sva #(.NUM_TRAP(NUM_TRAP), .NUM_IRQ(NUM_IRQ),
   .PM_LAT(PM_LAT), .RET_LAT(RET_LAT)) u_sva (.clk(clk), .rst_n(rst_n),
   .trap_pend(trap_pend), .irq_pend(irq_pend), .cpu_level(cpu_level),
   .interrupt_control_second(interrupt_control_second),
   .security_config_word(security_config_word),
   .boot_segment_defined(boot_segment_defined),
   .boot_segment_limit(boot_segment_limit), .core_ack(core_ack),
   .core_return(core_return), .pm_rd_data(pm_rd_data), .core_irq(core_irq),
   .core_irq_level(core_irq_level), .core_vec(core_vec),
   .core_vec_valid(core_vec_valid), .core_ret_done(core_ret_done),
   .pm_rd_en(pm_rd_en), .pm_rd_addr(pm_rd_addr), .alt_active(alt_active),
   .in_service(in_service));
`default_nettype wire

// ### testbench/vic_core_model.sv
/* Core and program memory model facing vic_top.
   Assumes one clock; delays come from the bench. */
`timescale 1ns/1ns
`default_nettype none
module vic_core_model
   import vic_pkg::*;
#(
   parameter int PM_LAT = VIC_PM_LAT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] ack_dly,
   input wire logic [2:0] ret_dly,
   input wire logic core_irq,
   input wire logic core_vec_valid,
   input wire logic pm_rd_en,
   input wire logic [VIC_ADDR_W-1:0] pm_rd_addr,
   output logic core_ack,
   output logic core_return,
   output logic [VIC_ADDR_W-1:0] pm_rd_data
);
   logic [3:0] acnt_ff;
   logic [3:0] rcnt_ff;
   logic [7:0] lat_ff;
   logic [VIC_ADDR_W-1:0] a_ff;
   logic [VIC_ADDR_W-1:0] junk_ff;
   always_ff @(posedge clk) begin
      if (!rst_n || !core_irq) begin
         acnt_ff <= 4'h0;
         core_ack <= 1'b0;
      end else begin
         core_ack <= acnt_ff == {1'b0, ack_dly} && !core_ack;
         acnt_ff <= acnt_ff + 4'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rcnt_ff <= 4'h0;
         core_return <= 1'b0;
      end else begin
         core_return <= rcnt_ff == 4'h1;
         if (core_vec_valid)
            rcnt_ff <= {1'b0, ret_dly} + 4'h1;
         else if (rcnt_ff != 4'h0)
            rcnt_ff <= rcnt_ff - 4'h1;
      end
   end
   // Data only valid in its slot; toggles elsewhere so stale reads show
   always_ff @(posedge clk) begin
      junk_ff <= rst_n ? ~junk_ff : 24'h5A5A5A;
      if (!rst_n)
         lat_ff <= 8'h00;
      else if (pm_rd_en) begin
         lat_ff <= 8'(PM_LAT);
         a_ff <= pm_rd_addr;
      end else if (lat_ff != 8'h00)
         lat_ff <= lat_ff - 8'h01;
   end
   assign pm_rd_data = lat_ff == 8'h01 ? a_ff ^ 24'hA5C35A : junk_ff;
endmodule // vic_core_model
`default_nettype wire

// ### testbench/vic_top_tb.sv
/* Self-checking bench for vic_top with a core model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
`default_nettype none
module vic_top_tb;
   import vic_pkg::*;
   localparam int PM_LAT = 2;
   localparam int RET_LAT = 3;
   logic clk, rst_n, ce, bsd, core_ack, core_return, core_irq, alt_active;
   logic core_vec_valid, core_ret_done, pm_rd_en, in_service;
   logic [7:0] trap_pend;
   logic [VIC_NUM_IRQ-1:0] irq_pend;
   vic_pri_type [VIC_NUM_IRQ-1:0] irq_level;
   vic_pri_type cpu_level;
   logic [15:0] ics, scw;
   logic [12:0] bsl;
   logic [23:0] pm_rd_data, pm_rd_addr;
   logic [2:0] ack_dly, ret_dly;
   vic_lvl_type core_irq_level;
   vic_vector_type core_vec;
   int seed, compares, mismatches;
   vic_top #(.PM_LAT(PM_LAT), .RET_LAT(RET_LAT)) i_dut (.clk(clk),
      .rst_n(rst_n), .ce(ce), .trap_pend(trap_pend), .irq_pend(irq_pend),
      .irq_level(irq_level), .cpu_level(cpu_level),
      .interrupt_control_second(ics), .security_config_word(scw),
      .boot_segment_defined(bsd), .boot_segment_limit(bsl),
      .core_ack(core_ack), .core_return(core_return),
      .pm_rd_data(pm_rd_data), .core_irq(core_irq),
      .core_irq_level(core_irq_level), .core_vec(core_vec),
      .core_vec_valid(core_vec_valid), .core_ret_done(core_ret_done),
      .pm_rd_en(pm_rd_en), .pm_rd_addr(pm_rd_addr),
      .alt_active(alt_active), .in_service(in_service));
   vic_core_model #(.PM_LAT(PM_LAT)) i_core (.clk(clk), .rst_n(rst_n),
      .ack_dly(ack_dly), .ret_dly(ret_dly), .core_irq(core_irq),
      .core_vec_valid(core_vec_valid), .pm_rd_en(pm_rd_en),
      .pm_rd_addr(pm_rd_addr), .core_ack(core_ack),
      .core_return(core_return), .pm_rd_data(pm_rd_data));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================================
   // Checking helpers
   // ==========================================================
   task print_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   function logic pick(input int sel);
      return sel == 0 ? core_irq : sel == 1 ? core_vec_valid : core_ret_done;
   endfunction
   task wait_for(input int sel, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (pick(sel) !== 1'b1 && n < lim);
      if (pick(sel) !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %s expected 1 seen 0", sel == 0 ? "core_irq" :
            sel == 1 ? "core_vec_valid" : "core_ret_done");
         print_verdict;
      end
   endtask
   // ==========================================================
   // One offer, fetch and return, or reset in service, against the reference model
   // ==========================================================
   task run_case(input bit rnd, input bit rst_mid);
      int best, blvl, ad;
      logic alt;
      @(posedge clk);
      if (rnd) begin
         ack_dly <= 3'($random(seed));
         ret_dly <= 3'($random(seed));
         cpu_level <= 3'($random(seed));
         ics <= 16'($random(seed));
         scw <= 16'($random(seed));
         bsd <= 1'($random(seed));
         bsl <= 13'($random(seed));
         trap_pend <= ($random(seed) & 3) == 0 ? 8'($random(seed)) : 8'h00;
         for (int j = 0; j < VIC_NUM_IRQ; j++) begin
            irq_pend[j] <= ($random(seed) & 7) == 0;
            irq_level[j] <= 3'($random(seed));
         end
      end
      @(negedge clk);
      best = -1;
      blvl = 0;
      for (int i = 7; i >= 0; i--)
         if (trap_pend[i]) begin
            best = i;
            blvl = 8;
         end
      for (int j = 0; j < VIC_NUM_IRQ; j++)
         if (blvl != 8 && irq_pend[j] && irq_level[j] > cpu_level &&
            irq_level[j] > blvl) begin
            best = 8 + j;
            blvl = irq_level[j];
         end
      if (best < 0) begin
         repeat (6) @(negedge clk);
         chk("core_irq", 0, core_irq);
      end else begin
         wait_for(0, 4);
         chk("core_irq_level", blvl, core_irq_level);
         wait_for(1, 24);
         alt = ics[8] & scw[15] & bsd;
         ad = ((alt ? ((bsl - 1) & 'h1FFF) * 'h800 : 4) + best * 2) & 'hFFFFFF;
         chk("alt_active", alt, alt_active);
         chk("pm_rd_addr", ad, pm_rd_addr);
         chk("core_vec", {24'(ad ^ 'hA5C35A), 4'(blvl), 7'(best)}, core_vec);
         chk("in_service", 1, in_service);
         @(posedge clk);
         trap_pend <= 8'h00;
         irq_pend <= '0;
         if (rst_mid) begin
            rst_n <= 1'b0;
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            @(negedge clk);
            chk("reset", 0, {core_vec, core_irq, in_service, pm_rd_en});
         end else begin
            wait_for(2, 16);
            chk("in_service", 0, in_service);
         end
      end
   endtask
   initial begin
      seed = 20;
      compares = 0;
      mismatches = 0;
      {rst_n, bsd, trap_pend, irq_pend, irq_level, cpu_level} = '0;
      {ics, scw, bsl, ack_dly, ret_dly} = '0;
      ce = 1'b1;
      repeat (16) @(posedge clk);
      @(negedge clk);
      chk("reset", 0, {core_vec, core_irq, in_service});
      @(posedge clk);
      rst_n <= 1'b1;
      // Level beats order, alternate table at a small limit
      irq_pend[3] <= 1'b1;
      irq_pend[5] <= 1'b1;
      irq_pend[100] <= 1'b1;
      {irq_level[3], irq_level[5], irq_level[100]} <= {3'h4, 3'h4, 3'h6};
      {cpu_level, ics, scw, bsd, bsl} <= {3'h3, 16'h0100, 16'h8000, 14'h2005};
      run_case(0, 0);
      @(posedge clk);
      irq_pend[3] <= 1'b1;
      irq_pend[5] <= 1'b1;
      ics <= 16'h0000;
      run_case(0, 0);
      @(posedge clk);
      trap_pend <= 8'h06;
      run_case(0, 1);
      repeat (60) run_case(1, 0);
      print_verdict;
   end
endmodule // vic_top_tb
`default_nettype wire
